// >>> hdl/dsm_regs.svh
// Register offsets, field positions, reset values and protocol codes
`ifndef DSM_REGS_SVH
`define DSM_REGS_SVH

// Register indices; byte address is four times the index
`define DSM_MAP_BASE 12'h340
`define DSM_MAP_LAST 12'h35F
`define DSM_MAP_22 12'h351
`define DSM_MAP_3A 12'h35D
`define DSM_MAP_3C 12'h35E
`define DSM_MAP_3E 12'h35F
`define DSM_CTRL 12'h370
`define DSM_COLOUR 12'h378

// Field positions
`define DSM_LO_LSB 0
`define DSM_HI_LSB 4
`define DSM_IGMP_EN 6
`define DSM_MLD_OPT 3
`define DSM_MLD_EN 2
`define DSM_SNIFF 0
`define DSM_RED_LSB 4
`define DSM_YEL_LSB 2
`define DSM_GRN_LSB 0

// Writable masks and reset values
`define DSM_CTRL_MASK 8'h4D
`define DSM_CTRL_RST 8'h00
`define DSM_COLOUR_MASK 8'h3F
`define DSM_COLOUR_RST 8'h39
`define DSM_PRIO_RST 3'h0

// Protocol and next header codes
`define DSM_PROTO_IGMP 8'h02
`define DSM_NH_HOP 8'h00
`define DSM_NH_ICMP4 8'h01
`define DSM_NH_ICMP6 8'h3A
`define DSM_NH_RTG 8'h2B
`define DSM_NH_FRAG 8'h2C
`define DSM_NH_ESP 8'h32
`define DSM_NH_AH 8'h33
`define DSM_NH_DST 8'h3C

`endif

// >>> hdl/dsm_pkg.sv
// Shared types of the DSCP map and snoop/mirror control block
package dsm_pkg;
  typedef logic [2:0] dsm_prio_t;
  typedef enum logic {
    DSM_RX_OR_TX,
    DSM_RX_AND_TX
  } dsm_sniff_t;
endpackage

// >>> hdl/dsm_classify.sv
// Snoop and mirror decision for one frame per cycle
`timescale 1ns/10ps
`include "dsm_regs.svh"
module dsm_classify (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Control bits
  input wire logic igmp_en_in,
  input wire logic mld_en_in,
  input wire logic mld_opt_in,
  input wire dsm_pkg::dsm_sniff_t sniff_in,
  // Frame descriptor
  input wire logic pkt_valid_in,
  input wire logic pkt_is_ipv4_in,
  input wire logic pkt_is_ipv6_in,
  input wire logic [7:0] pkt_ipv4_proto_in,
  input wire logic [7:0] pkt_next_hdr_in,
  input wire logic [7:0] pkt_hbh_next_hdr_in,
  input wire logic pkt_src_match_in,
  input wire logic pkt_dst_match_in,
  // Decision
  output logic valid_out,
  output logic to_host_out,
  output logic mirror_out
);

  function automatic logic nh_hit(input logic opt, input logic [7:0] nh);
    logic base;
    logic ext;
    base = (nh == `DSM_NH_ICMP4) || (nh == `DSM_NH_ICMP6);
    ext = (nh == `DSM_NH_RTG) || (nh == `DSM_NH_FRAG) || (nh == `DSM_NH_ESP) ||
          (nh == `DSM_NH_AH) || (nh == `DSM_NH_DST);
    return opt ? ext : base;
  endfunction

  wire logic igmp_hit = pkt_is_ipv4_in && (pkt_ipv4_proto_in == `DSM_PROTO_IGMP);
  // Hop-by-hop header is looked through only one level deep
  wire logic mld_nh = nh_hit(mld_opt_in, pkt_next_hdr_in);
  wire logic mld_hbh = (pkt_next_hdr_in == `DSM_NH_HOP) &&
                       nh_hit(mld_opt_in, pkt_hbh_next_hdr_in);
  wire logic mld_hit = pkt_is_ipv6_in && (mld_nh || mld_hbh);
  wire logic snoop = (igmp_en_in && igmp_hit) || (mld_en_in && mld_hit);
  wire logic both = pkt_src_match_in && pkt_dst_match_in;
  wire logic either = pkt_src_match_in || pkt_dst_match_in;
  wire logic mirror = (sniff_in == dsm_pkg::DSM_RX_AND_TX) ? both : either;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      valid_out <= 1'b0;
      to_host_out <= 1'b0;
      mirror_out <= 1'b0;
    end else begin
      valid_out <= pkt_valid_in;
      to_host_out <= pkt_valid_in && snoop;
      mirror_out <= pkt_valid_in && mirror;
    end
  end

endmodule

// >>> hdl/dsm_dscp_snoop_mirror_ctrl.sv
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "dsm_regs.svh"
module dsm_dscp_snoop_mirror_ctrl #(
  parameter int ADDR_W = 14,
  parameter int MAP_REGS = 32
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Frame descriptor from the parser
  input wire logic pkt_valid_in,
  input wire logic pkt_is_ipv4_in,
  input wire logic pkt_is_ipv6_in,
  input wire logic [5:0] pkt_dscp_in,
  input wire logic [7:0] pkt_ipv4_proto_in,
  input wire logic [7:0] pkt_next_hdr_in,
  input wire logic [7:0] pkt_hbh_next_hdr_in,
  input wire logic pkt_src_match_in,
  input wire logic pkt_dst_match_in,
  // Frame decision
  output logic res_valid_out,
  output logic res_prio_valid_out,
  output logic [2:0] res_prio_out,
  output logic res_to_host_out,
  output logic res_mirror_out,
  // WRED colour code points
  output logic [1:0] colour_red_out,
  output logic [1:0] colour_yellow_out,
  output logic [1:0] colour_green_out
);

  if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must be 12 to 32");
  end
  if (MAP_REGS != 32) begin : g_bad_map
    $error("MAP_REGS must be 32 to cover 64 code points");
  end

  localparam int IW = ADDR_W - 2;
  localparam logic [IW-1:0] I_BASE = IW'(`DSM_MAP_BASE);
  localparam logic [IW-1:0] I_LAST = IW'(`DSM_MAP_LAST);
  localparam logic [IW-1:0] I_CTRL = IW'(`DSM_CTRL);
  localparam logic [IW-1:0] I_COL = IW'(`DSM_COLOUR);

  logic ack;
  logic [7:0] ctrl;
  logic [7:0] colour;
  logic [3*MAP_REGS-1:0] lo_vec;
  logic [3*MAP_REGS-1:0] hi_vec;

  // Bus decode
  wire logic [IW-1:0] widx = avs_address_in[ADDR_W-1:2];
  wire logic req = avs_read_in | avs_write_in;
  wire logic hit_map = (widx >= I_BASE) && (widx <= I_LAST);
  wire logic hit_ctrl = widx == I_CTRL;
  wire logic hit_col = widx == I_COL;
  wire logic [4:0] sel = widx[4:0];
  // Only byte lane 0 holds data; other lanes are ignored
  wire logic wr_go = avs_write_in & ack & avs_byteenable_in[0];
  wire logic wr_map = wr_go & hit_map;
  wire logic wr_ctrl = wr_go & hit_ctrl;
  wire logic wr_col = wr_go & hit_col;
  wire logic [7:0] wbyte = avs_writedata_in[7:0];

  // Every access waits exactly one cycle, so read data can be registered
  assign avs_waitrequest_out = req & ~ack;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // Priority map bank, two code points per register
  for (genvar g = 0; g < MAP_REGS; g++) begin : g_map
    logic [2:0] lo;
    logic [2:0] hi;
    wire logic wr_me = wr_map && (sel == 5'(g));
    always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
        lo <= `DSM_PRIO_RST;
        hi <= `DSM_PRIO_RST;
      end else if (wr_me) begin
        lo <= wbyte[`DSM_LO_LSB +: 3];
        hi <= wbyte[`DSM_HI_LSB +: 3];
      end
    end
    assign lo_vec[3*g +: 3] = lo;
    assign hi_vec[3*g +: 3] = hi;
  end

  // Reserved control bits are masked so they always read zero
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ctrl <= `DSM_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= wbyte & `DSM_CTRL_MASK;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      colour <= `DSM_COLOUR_RST;
    end else if (wr_col) begin
      colour <= wbyte & `DSM_COLOUR_MASK;
    end
  end

  // Read path; unmapped words read as zero and ignore writes
  wire logic [2:0] rd_lo = lo_vec[3*sel +: 3];
  wire logic [2:0] rd_hi = hi_vec[3*sel +: 3];
  wire logic [7:0] rd_map = {1'b0, rd_hi, 1'b0, rd_lo};
  wire logic [7:0] rd_byte = hit_map ? rd_map :
                             hit_ctrl ? ctrl :
                             hit_col ? colour : 8'h00;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (avs_read_in & ~ack) begin
      avs_readdata_out <= {24'h000000, rd_byte};
    end
  end

  // Priority lookup by DSCP
  wire logic [4:0] lk = pkt_dscp_in[5:1];
  wire dsm_pkg::dsm_prio_t lk_lo = lo_vec[3*lk +: 3];
  wire dsm_pkg::dsm_prio_t lk_hi = hi_vec[3*lk +: 3];
  wire dsm_pkg::dsm_prio_t lk_prio = pkt_dscp_in[0] ? lk_hi : lk_lo;
  wire logic is_ip = pkt_valid_in & (pkt_is_ipv4_in | pkt_is_ipv6_in);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      res_prio_valid_out <= 1'b0;
      res_prio_out <= `DSM_PRIO_RST;
    end else begin
      res_prio_valid_out <= is_ip;
      res_prio_out <= is_ip ? lk_prio : `DSM_PRIO_RST;
    end
  end

  // Mirror match inputs already carry the per-port settings
  dsm_classify u_classify (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .igmp_en_in(ctrl[`DSM_IGMP_EN]),
    .mld_en_in(ctrl[`DSM_MLD_EN]),
    .mld_opt_in(ctrl[`DSM_MLD_OPT]),
    .sniff_in(dsm_pkg::dsm_sniff_t'(ctrl[`DSM_SNIFF])),
    .pkt_valid_in(pkt_valid_in),
    .pkt_is_ipv4_in(pkt_is_ipv4_in),
    .pkt_is_ipv6_in(pkt_is_ipv6_in),
    .pkt_ipv4_proto_in(pkt_ipv4_proto_in),
    .pkt_next_hdr_in(pkt_next_hdr_in),
    .pkt_hbh_next_hdr_in(pkt_hbh_next_hdr_in),
    .pkt_src_match_in(pkt_src_match_in),
    .pkt_dst_match_in(pkt_dst_match_in),
    .valid_out(res_valid_out),
    .to_host_out(res_to_host_out),
    .mirror_out(res_mirror_out)
  );

  assign colour_red_out = colour[`DSM_RED_LSB +: 2];
  assign colour_yellow_out = colour[`DSM_YEL_LSB +: 2];
  assign colour_green_out = colour[`DSM_GRN_LSB +: 2];

  // Checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  wire logic pkt_v4 = pkt_valid_in && pkt_is_ipv4_in;
  wire logic pkt_v6 = pkt_valid_in && pkt_is_ipv6_in && !pkt_is_ipv4_in;
  wire logic wr_3a = wr_map && (widx == IW'(`DSM_MAP_3A));
  wire logic wr_22 = wr_map && (widx == IW'(`DSM_MAP_22));
  wire logic rd_3e = avs_read_in && !ack && (widx == IW'(`DSM_MAP_3E));
  wire logic nh_icmp6 = pkt_next_hdr_in == `DSM_NH_ICMP6;
  wire logic nh_hbh_ah = (pkt_next_hdr_in == `DSM_NH_HOP) &&
                         (pkt_hbh_next_hdr_in == `DSM_NH_AH);
  wire logic nh_hbh_icmp4 = (pkt_next_hdr_in == `DSM_NH_HOP) &&
                            (pkt_hbh_next_hdr_in == `DSM_NH_ICMP4);
  wire logic pkt_ip = pkt_valid_in && (pkt_is_ipv4_in || pkt_is_ipv6_in);

  bus_wait_a: assert property (
    req && !ack |=> !avs_waitrequest_out || !req)
    else $error("access not answered after one wait cycle");

  map_3a_a: assert property (
    wr_3a ##1 (pkt_v4 && pkt_dscp_in == 6'h3A && !wr_map) |=>
      res_prio_out == $past(avs_writedata_in[2:0], 2))
    else $error("DSCP 0x3A priority not taken from its register");

  map_3d_a: assert property (
    pkt_valid_in && pkt_is_ipv6_in && pkt_dscp_in == 6'h3D |=>
      res_prio_valid_out && res_prio_out == $past(hi_vec[3*30 +: 3]))
    else $error("DSCP 0x3D priority not from high field");

  map_resv_a: assert property (
    rd_3e |=> avs_readdata_out[7] == 1'b0 && avs_readdata_out[3] == 1'b0 &&
      avs_readdata_out[6:4] == $past(hi_vec[3*31 +: 3]))
    else $error("reserved bits of DSCP 0x3E/0x3F register not zero");

  map_pair_a: assert property (
    wr_22 |=> hi_vec[3*17 +: 3] == $past(avs_writedata_in[6:4]) &&
      lo_vec[3*17 +: 3] == $past(avs_writedata_in[2:0]))
    else $error("register 0x351 did not store its two fields");

  nonip_prio_a: assert property (
    pkt_valid_in && !pkt_is_ipv4_in && !pkt_is_ipv6_in |=> !res_prio_valid_out)
    else $error("priority flagged for a non-IP frame");

  igmp_host_a: assert property (
    pkt_v4 && pkt_ipv4_proto_in == `DSM_PROTO_IGMP |=>
      res_to_host_out == $past(ctrl[`DSM_IGMP_EN]))
    else $error("IGMP forwarding does not follow its enable");

  mld_base_a: assert property (
    pkt_v6 && nh_icmp6 && ctrl[`DSM_MLD_EN] && !ctrl[`DSM_MLD_OPT] |=> res_to_host_out)
    else $error("ICMPv6 frame not snooped with option clear");

  mld_off_a: assert property (
    pkt_v6 && !ctrl[`DSM_MLD_EN] |=> !res_to_host_out)
    else $error("IPv6 frame snooped while MLD snooping disabled");

  mld_ext_a: assert property (
    pkt_v6 && nh_hbh_ah && ctrl[`DSM_MLD_EN] |=>
      res_to_host_out == $past(ctrl[`DSM_MLD_OPT]))
    else $error("hop-by-hop extension match does not follow option");

  sniff_and_a: assert property (
    pkt_valid_in && ctrl[`DSM_SNIFF] && (pkt_src_match_in != pkt_dst_match_in)
      |=> !res_mirror_out)
    else $error("single-side match mirrored in AND mode");

  sniff_or_a: assert property (
    pkt_valid_in && !ctrl[`DSM_SNIFF] && (pkt_src_match_in || pkt_dst_match_in)
      |=> res_mirror_out)
    else $error("single-side match not mirrored in OR mode");

  colour_rst_a: assert property (
    @(posedge core_clk_in) disable iff (1'b0)
    sys_rst_in |=> colour_red_out == 2'h3 && colour_yellow_out == 2'h2 &&
      colour_green_out == 2'h1)
    else $error("colour map reset values wrong");

  colour_wr_a: assert property (
    wr_col |=> colour_green_out == $past(avs_writedata_in[1:0]) &&
      colour[7:6] == 2'h0)
    else $error("colour register write not stored or reserved bits set");

  map_3b_a: assert property (
    pkt_ip && pkt_dscp_in == 6'h3B |=> res_prio_out == $past(hi_vec[3*29 +: 3]))
    else $error("DSCP 0x3B priority not from high field");

  map_3c_a: assert property (
    pkt_ip && pkt_dscp_in == 6'h3C |=> res_prio_out == $past(lo_vec[3*30 +: 3]))
    else $error("DSCP 0x3C priority not from low field");

  map_3e_a: assert property (
    pkt_ip && pkt_dscp_in == 6'h3E |=> res_prio_out == $past(lo_vec[3*31 +: 3]))
    else $error("DSCP 0x3E priority not from low field");

  map_3f_a: assert property (
    pkt_ip && pkt_dscp_in == 6'h3F |=> res_prio_out == $past(hi_vec[3*31 +: 3]))
    else $error("DSCP 0x3F priority not from high field");

  rd_upper_a: assert property (
    avs_read_in && !ack |=> avs_readdata_out[31:8] == 24'h000000)
    else $error("read data upper bytes not zero");

  ip_prio_a: assert property (
    pkt_ip |=> res_prio_valid_out && res_valid_out)
    else $error("IP frame without a priority result");

  prio_zero_a: assert property (
    !res_prio_valid_out |-> res_prio_out == 3'h0)
    else $error("priority not zero while not flagged");

  ctrl_mask_a: assert property (
    (ctrl & ~`DSM_CTRL_MASK) == 8'h00)
    else $error("reserved control bit set");

  ctrl_wr_a: assert property (
    wr_ctrl |=> ctrl[`DSM_MLD_EN] == $past(avs_writedata_in[2]) &&
      ctrl[`DSM_IGMP_EN] == $past(avs_writedata_in[6]))
    else $error("control enables not stored on write");

  mld_hbh_base_a: assert property (
    pkt_v6 && nh_hbh_icmp4 && ctrl[`DSM_MLD_EN] && !ctrl[`DSM_MLD_OPT] |=> res_to_host_out)
    else $error("hop-by-hop ICMP frame not snooped with option clear");

  mld_opt_base_a: assert property (
    pkt_v6 && nh_icmp6 && ctrl[`DSM_MLD_OPT] |=> !res_to_host_out)
    else $error("ICMPv6 frame snooped with option set");

  sniff_both_a: assert property (
    pkt_valid_in && pkt_src_match_in && pkt_dst_match_in |=> res_mirror_out)
    else $error("double match not mirrored");

  sniff_none_a: assert property (
    pkt_valid_in && !pkt_src_match_in && !pkt_dst_match_in |=> !res_mirror_out)
    else $error("frame mirrored without any match");

  colour_red_a: assert property (
    wr_col |=> colour_red_out == $past(avs_writedata_in[5:4]))
    else $error("red code point not stored");

  colour_yel_a: assert property (
    wr_col |=> colour_yellow_out == $past(avs_writedata_in[3:2]))
    else $error("yellow code point not stored");

  // Idle cycles must not produce a result
  idle_res_a: assert property (
    !pkt_valid_in |=> !res_valid_out && !res_to_host_out && !res_mirror_out)
    else $error("result produced without a frame");

  rd_ack_c: cover property (avs_read_in && avs_waitrequest_out ##1 !avs_waitrequest_out);
  sniff_or_c: cover property (!ctrl[`DSM_SNIFF] && pkt_valid_in && !pkt_dst_match_in ##1
    res_mirror_out);
  igmp_c: cover property (pkt_v4 && ctrl[`DSM_IGMP_EN] ##1 res_to_host_out);
  mld_hbh_c: cover property (pkt_v6 && nh_hbh_ah && ctrl[`DSM_MLD_OPT] ##1 res_to_host_out);
  mirror_and_c: cover property (ctrl[`DSM_SNIFF] && pkt_valid_in ##1 res_mirror_out);

endmodule

// >>> verif/test_dscp_snoop_mirror_ctrl.sv
// Self-checking bench for the DSCP map and snoop/mirror control block
`timescale 1ns/10ps
module test_dscp_snoop_mirror_ctrl;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [13:0] addr = 14'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdata;
  logic wreq;
  logic pv = 1'b0;
  logic p4 = 1'b0;
  logic p6 = 1'b0;
  logic [5:0] dscp = 6'h0;
  logic [7:0] proto = 8'h0;
  logic [7:0] nh = 8'h0;
  logic [7:0] hbh = 8'h0;
  logic sm = 1'b0;
  logic dm = 1'b0;
  logic r_valid, r_pvalid, r_host, r_mir;
  logic [2:0] r_prio;
  logic [1:0] red, yel, grn;
  int errors = 0;
  int n_compared = 0;
  int seed = 54287;
  logic [2:0] map [64];
  logic [7:0] nh_tbl [10] = '{8'h00, 8'h01, 8'h3A, 8'h2B, 8'h2C, 8'h32, 8'h33, 8'h3C,
                             8'h11, 8'h06};

  dsm_dscp_snoop_mirror_ctrl u_dut (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .pkt_valid_in(pv), .pkt_is_ipv4_in(p4), .pkt_is_ipv6_in(p6), .pkt_dscp_in(dscp),
    .pkt_ipv4_proto_in(proto), .pkt_next_hdr_in(nh), .pkt_hbh_next_hdr_in(hbh),
    .pkt_src_match_in(sm), .pkt_dst_match_in(dm),
    .res_valid_out(r_valid), .res_prio_valid_out(r_pvalid), .res_prio_out(r_prio),
    .res_to_host_out(r_host), .res_mirror_out(r_mir),
    .colour_red_out(red), .colour_yellow_out(yel), .colour_green_out(grn)
  );

  always #20 core_clk_in = ~core_clk_in;

  task automatic fail(input string m);
    errors++;
    $display("ERROR t=%0t %s", $time, m);
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask

  task automatic chk_frame(input logic [6:0] got, input logic [6:0] exp);
    n_compared++;
    if (got !== exp) fail($sformatf("frame result got %h exp %h", got, exp));
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Holds the request until waitrequest is seen low, then releases after that edge
  task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int n;
    logic [31:0] r;
    r = $random(seed);
    @(posedge core_clk_in);
    addr <= {idx, 2'b00};
    rd <= !w;
    wr <= w;
    wdata <= {r[31:8], d};
    be <= b;
    n = 0;
    do begin
      @(negedge core_clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (wreq !== 1'b0) fail("bus request never answered");
    // Accepting edge: the write lands and read data is taken here
    @(posedge core_clk_in);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rw_chk(input logic [11:0] idx, input logic [7:0] d, input logic [3:0] b,
                        input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b1, idx, d, b, q);
    bus(1'b0, idx, 8'h00, 4'hF, q);
    chk_reg(q, {24'h0, exp}, $sformatf("readback of %h", idx));
  endtask

  function automatic logic nh_hit(input logic opt, input logic [7:0] v);
    if (opt) return v inside {8'h2B, 8'h2C, 8'h32, 8'h33, 8'h3C};
    return v inside {8'h01, 8'h3A};
  endfunction

  initial begin
    logic [31:0] q, t;
    logic [7:0] d;
    logic [3:0] c;
    logic [6:0] e, next_e;
    logic ev, next_ev, i4, i6;
    repeat (6) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    // Reset values of map registers 0x35D to 0x35F, control and colour
    for (int k = 0; k < 3; k++) begin
      bus(1'b0, 12'h35D + 12'(k), 8'h00, 4'hF, q);
      chk_reg(q, 32'h0, "map reset");
    end
    bus(1'b0, 12'h370, 8'h00, 4'hF, q);
    chk_reg(q, 32'h0, "ctrl reset");
    bus(1'b0, 12'h378, 8'h00, 4'hF, q);
    chk_reg(q, 32'h39, "colour reset");
    chk_reg({26'h0, red, yel, grn}, 32'h39, "colour outs reset");
    $display("test reset values done");
    // Reserved bits dropped, ignored byte lane, unmapped place
    rw_chk(12'h35D, 8'hFF, 4'hF, 8'h77);
    rw_chk(12'h35D, 8'h00, 4'hE, 8'h77);
    rw_chk(12'h35E, 8'hFF, 4'hF, 8'h77);
    rw_chk(12'h35F, 8'hFF, 4'hF, 8'h77);
    rw_chk(12'h370, 8'hFF, 4'hF, 8'h4D);
    rw_chk(12'h371, 8'hFF, 4'hF, 8'h00);
    for (int k = 0; k < 4; k++) begin
      d = 8'($random(seed));
      rw_chk(12'h378, d, 4'hF, d & 8'h3F);
      chk_reg({26'h0, red, yel, grn}, {26'h0, d[5:0]}, "colour outs");
    end
    $display("test register access done");
    // Whole map bank with random priorities, read back
    for (int k = 0; k < 32; k++) begin
      d = 8'($random(seed));
      map[2 * k] = d[2:0];
      map[2 * k + 1] = d[6:4];
      rw_chk(12'h340 + 12'(k), d, 4'hF, d & 8'h77);
    end
    $display("test map bank done");
    // Every control combination; match inputs stand for per-port settings
    for (int k = 0; k < 16; k++) begin
      c = 4'(k);
      rw_chk(12'h370, {1'b1, c[3], 2'b11, c[2], c[1], 1'b1, c[0]}, 4'hF,
             {1'b0, c[3], 2'b00, c[2], c[1], 1'b0, c[0]});
      ev = 1'b0;
      for (int i = 0; i <= 40; i++) begin
        @(posedge core_clk_in);
        t = $random(seed);
        next_ev = (i < 40) && (t[0] | t[1]);
        i4 = t[3:2] == 2'd0;
        i6 = t[3:2] == 2'd1 || t[3:2] == 2'd2;
        pv <= next_ev;
        p4 <= i4;
        p6 <= i6;
        dscp <= t[9:4];
        proto <= t[10] ? 8'h02 : t[18:11];
        nh <= nh_tbl[t[23:20] % 10];
        hbh <= nh_tbl[t[27:24] % 10];
        sm <= t[28];
        dm <= t[29];
        next_e[6] = next_ev;
        next_e[5] = i4 | i6;
        next_e[4:2] = (i4 | i6) ? map[t[9:4]] : 3'h0;
        next_e[1] = (c[3] & i4 & (t[10] || t[18:11] == 8'h02)) |
                    (c[1] & i6 & (nh_hit(c[2], nh_tbl[t[23:20] % 10]) ||
                     (t[23:20] % 10 == 0 && nh_hit(c[2], nh_tbl[t[27:24] % 10]))));
        next_e[0] = c[0] ? (t[28] & t[29]) : (t[28] | t[29]);
        @(negedge core_clk_in);
        if (i > 0 && ev) chk_frame({r_valid, r_pvalid, r_prio, r_host, r_mir}, e);
        if (i > 0 && !ev) chk_reg({31'h0, r_valid}, 32'h0, "idle result");
        ev = next_ev;
        e = next_e;
      end
    end
    $display("test frame decisions done");
    conclude();
  end

  initial begin
    #(40 * 40000);
    fail("watchdog expired");
    conclude();
  end
endmodule
